/* File: hw/sxm_ext_mii.sv */
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/10ps
`include "sxm_cfg.svh"
// Operation
// R1: pause strap 1 enables port A flow control
// R2: role strap 1 MAC role, 0 PHY role
// R3: role strap never changes port B behaviour
// R4: management settings configure duplex of ports
// R5: PHY role: drive tx clock, sample rising
// R6: PHY role: tx data valid only with enable
// R7: PHY role: collision only half duplex event
// R8: PHY role: rx launched on tx clock falling
// R9: PHY role: no clock on rx clock pin
// R10: MAC role: tx clock is an input
// R11: MAC role: drive tx on clock rising
// R12: MAC role: collision is an input
// R13: MAC role: accept rx only while valid
// R14: MAC role: capture rx on rx clock rising
// R15: port B PHY role, drives tx clock
// R16: port B tx data valid only with enable
// R17: port B collision only half duplex event
// R18: port B rx clock out, launch falling
// R19: external port strap 0 disables interface
// R20: interface-type strap 1 disables nibble interface
// R21: straps sampled once after reset release
// R22: MAC role clocks crossed into system clock
module sxm_ext_mii import sxm_pkg::*; (
	input wire logic sys_clk, // system clock
	input wire logic reset_n, // async reset
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write flag
	input wire logic [2:0] hsize, // transfer size
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic hreadyout, // slave ready
	output logic [31:0] hrdata, // read data
	output logic hresp, // response
	input wire logic extPortEnableStrap, // external port strap
	input wire logic portARoleSelect, // role strap
	input wire logic portAPauseEnableStrap, // pause strap
	input wire logic interfaceTypeStrap, // interface type strap
	input wire logic portATxClockIn, // port A tx clock in
	output logic portATxClockOut, // port A tx clock out
	output logic portATxClockOe, // port A tx clock enable
	input wire sxm_nibble_t portATxNibbleIn, // port A tx data in
	output sxm_nibble_t portATxNibbleOut, // port A tx data out
	output logic portATxNibbleOe, // port A tx data enable
	input wire logic portATxEnableIn, // port A tx enable in
	output logic portATxEnableOut, // port A tx enable out
	output logic portATxEnableOe, // port A tx enable oe
	input wire logic portACollisionIn, // port A collision in
	output logic portACollisionOut, // port A collision out
	output logic portACollisionOe, // port A collision oe
	input wire logic portARxValidIn, // port A rx valid in
	output logic portARxValidOut, // port A rx valid out
	output logic portARxValidOe, // port A rx valid oe
	input wire sxm_nibble_t portARxNibbleIn, // port A rx data in
	output sxm_nibble_t portARxNibbleOut, // port A rx data out
	output logic portARxNibbleOe, // port A rx data oe
	input wire logic portARxClockIn, // port A rx clock in
	output logic portARxClockOut, // port A rx clock out
	output logic portARxClockOe, // port A rx clock oe
	output logic portBTxClock, // port B tx clock
	input wire sxm_nibble_t portBTxNibble, // port B tx data
	input wire logic portBTxEnable, // port B tx enable
	output logic portBCollision, // port B collision
	output logic portBRxValid, // port B rx valid
	output sxm_nibble_t portBRxNibble, // port B rx data
	output logic portBRxClock, // port B rx clock
	output logic portBOe, // port B outputs enable
	input wire logic portAColEvent, // switch port 4 collision
	input wire logic portBColEvent, // wan transceiver collision
	input wire sxm_nibble_t egrANibble, // switch to port A data
	input wire logic egrAValid, // switch to port A valid
	output logic egrAReady, // port A takes nibble
	input wire sxm_nibble_t egrBNibble, // switch to port B data
	input wire logic egrBValid, // switch to port B valid
	output logic egrBReady, // port B takes nibble
	output sxm_nibble_t ingANibble, // port A to switch data
	output logic ingAValid, // port A to switch valid
	output sxm_nibble_t ingBNibble, // port B to switch data
	output logic ingBValid, // port B to switch valid
	output logic portAColSeen, // MAC role collision in
	output logic portAPauseEnable // flow control to switch
);
	// ****************************************
	// functions
	// ****************************************
	function automatic logic [15:0] incr16(input logic [15:0] v);
		incr16 = v + 16'h0001;
	endfunction : incr16

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [`SXM_SYNC_W-1:0] pinRaw;
	logic [`SXM_SYNC_W-1:0] sync1_q;
	logic [`SXM_SYNC_W-1:0] sync2_q;
	assign pinRaw = {portBTxEnable, portBTxNibble, portARxClockIn, portARxNibbleIn, portARxValidIn,
		portACollisionIn, portATxEnableIn, portATxNibbleIn, portATxClockIn, interfaceTypeStrap,
		portAPauseEnableStrap, portARoleSelect, extPortEnableStrap};
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= pinRaw;
			sync2_q <= sync1_q;
		end
	end

	// ****************************************
	// strap capture
	// ****************************************
	logic [1:0] strapCnt_q;
	logic latched_q;
	logic extEn_q;
	logic ifType_q;
	logic pause_q;
	sxm_mode_t mode_q;
	sxm_mode_t modeD;
	wire strapTake = !latched_q && (strapCnt_q == `SXM_STRAP_WAIT);
	assign modeD = (!sync2_q[`SXM_S_EXT] || sync2_q[`SXM_S_IFTYPE]) ? SXM_OFF : // R19 R20
		(sync2_q[`SXM_S_ROLE] ? SXM_MAC : SXM_PHY); // R2
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			strapCnt_q <= '0;
			latched_q <= 1'b0;
			extEn_q <= 1'b0;
			ifType_q <= 1'b0;
			pause_q <= 1'b0;
			mode_q <= SXM_OFF;
		end else if (!latched_q) begin
			strapCnt_q <= strapCnt_q + 2'h1;
			if (strapTake) begin // R21
				latched_q <= 1'b1;
				extEn_q <= sync2_q[`SXM_S_EXT];
				ifType_q <= sync2_q[`SXM_S_IFTYPE];
				pause_q <= sync2_q[`SXM_S_PAUSE];
				mode_q <= modeD;
			end
		end
	end
	wire active = (mode_q != SXM_OFF);
	logic isPhy;
	logic isMac;
	always_comb begin
		case (mode_q)
			SXM_PHY: begin
				isPhy = 1'b1;
				isMac = 1'b0;
			end
			SXM_MAC: begin
				isPhy = 1'b0;
				isMac = 1'b1;
			end
			default: begin
				isPhy = 1'b0;
				isMac = 1'b0;
			end
		endcase
	end
	assign portAPauseEnable = active && pause_q; // R1

	// ****************************************
	// link clock divider
	// ****************************************
	logic [7:0] divCnt_q;
	logic linkClk_q;
	wire divEnd = (divCnt_q == 8'(`SXM_HALF_CYCLES - 1));
	wire riseEv = divEnd && !linkClk_q;
	wire fallEv = divEnd && linkClk_q;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			divCnt_q <= '0;
			linkClk_q <= 1'b0;
		end else begin
			divCnt_q <= divEnd ? 8'h00 : divCnt_q + 8'h01;
			if (divEnd)
				linkClk_q <= !linkClk_q;
		end
	end

	// ****************************************
	// MAC role edge detection
	// ****************************************
	logic aTxClkPrev_q;
	logic aRxClkPrev_q;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			aTxClkPrev_q <= 1'b0;
			aRxClkPrev_q <= 1'b0;
		end else begin
			aTxClkPrev_q <= sync2_q[`SXM_S_ATXCLK];
			aRxClkPrev_q <= sync2_q[`SXM_S_ARXCLK];
		end
	end
	wire macTxRise = sync2_q[`SXM_S_ATXCLK] && !aTxClkPrev_q; // R10 R22
	wire macRxRise = sync2_q[`SXM_S_ARXCLK] && !aRxClkPrev_q; // R14 R22

	// ****************************************
	// control and counters
	// ****************************************
	logic [1:0] ctrl_q;
	logic [15:0] cntA_q;
	logic [15:0] cntB_q;
	wire halfA = ctrl_q[`SXM_CTRL_HALF_A];
	wire halfB = ctrl_q[`SXM_CTRL_HALF_B];

	// ****************************************
	// port A datapath
	// ****************************************
	wire aEgrEv = active && (isPhy ? fallEv : macTxRise); // R8 R11
	wire aIngEv = isPhy ? riseEv : (isMac && macRxRise); // R5 R14
	wire aIngOk = isPhy ? sync2_q[`SXM_S_ATXEN] : sync2_q[`SXM_S_ARXDV]; // R6 R13
	wire [3:0] aIngData = isPhy ? sync2_q[`SXM_S_ATXNIB +: 4] : sync2_q[`SXM_S_ARXNIB +: 4];
	logic [3:0] aEgrNib_q;
	logic aEgrVal_q;
	logic aCol_q;
	logic aColSeen_q;
	logic [3:0] aIngNib_q;
	logic aIngVal_q;
	assign egrAReady = aEgrEv;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			aEgrNib_q <= '0;
			aEgrVal_q <= 1'b0;
			aCol_q <= 1'b0;
			aColSeen_q <= 1'b0;
			aIngNib_q <= '0;
			aIngVal_q <= 1'b0;
		end else begin
			if (aEgrEv) begin
				aEgrNib_q <= egrAValid ? egrANibble : 4'h0;
				aEgrVal_q <= egrAValid;
			end
			aCol_q <= isPhy && halfA && portAColEvent; // R7
			aColSeen_q <= isMac && sync2_q[`SXM_S_ACOL]; // R12
			aIngVal_q <= aIngEv && aIngOk;
			if (aIngEv && aIngOk)
				aIngNib_q <= aIngData;
		end
	end
	assign portATxClockOut = linkClk_q; // R5
	assign portATxClockOe = isPhy; // R10
	assign portATxNibbleOut = aEgrNib_q;
	assign portATxNibbleOe = isMac; // R11
	assign portATxEnableOut = aEgrVal_q;
	assign portATxEnableOe = isMac;
	assign portACollisionOut = aCol_q;
	assign portACollisionOe = isPhy; // R12
	assign portARxValidOut = aEgrVal_q;
	assign portARxValidOe = isPhy; // R8
	assign portARxNibbleOut = aEgrNib_q;
	assign portARxNibbleOe = isPhy;
	assign portARxClockOut = 1'b0;
	assign portARxClockOe = 1'b0; // R9
	assign ingANibble = aIngNib_q;
	assign ingAValid = aIngVal_q;
	assign portAColSeen = aColSeen_q;

	// ****************************************
	// port B datapath, independent of role strap
	// ****************************************
	wire bOn = active; // R3 R19
	wire bIngOk = sync2_q[`SXM_S_BTXEN]; // R16
	logic [3:0] bEgrNib_q;
	logic bEgrVal_q;
	logic bCol_q;
	logic [3:0] bIngNib_q;
	logic bIngVal_q;
	assign egrBReady = bOn && fallEv;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			bEgrNib_q <= '0;
			bEgrVal_q <= 1'b0;
			bCol_q <= 1'b0;
			bIngNib_q <= '0;
			bIngVal_q <= 1'b0;
		end else begin
			if (bOn && fallEv) begin // R18
				bEgrNib_q <= egrBValid ? egrBNibble : 4'h0;
				bEgrVal_q <= egrBValid;
			end
			bCol_q <= bOn && halfB && portBColEvent; // R17
			bIngVal_q <= bOn && riseEv && bIngOk; // R15
			if (bOn && riseEv && bIngOk)
				bIngNib_q <= sync2_q[`SXM_S_BTXNIB +: 4];
		end
	end
	assign portBTxClock = linkClk_q; // R15
	assign portBRxClock = linkClk_q; // R18
	assign portBCollision = bCol_q;
	assign portBRxValid = bEgrVal_q;
	assign portBRxNibble = bEgrNib_q;
	assign portBOe = bOn;
	assign ingBNibble = bIngNib_q;
	assign ingBValid = bIngVal_q;

	// ****************************************
	// AHB-Lite slave
	// ****************************************
	logic wrPend_q;
	logic [`SXM_ADDR_MSB:0] wrAddr_q;
	logic [31:0] rdata_q;
	wire take = hsel && hready && htrans[1];
	wire [`SXM_ADDR_MSB:0] aAddr = haddr[`SXM_ADDR_MSB:0];
	wire [31:0] statusWord = {25'h000_0000, aColSeen_q, isMac, latched_q, ifType_q, pause_q, isMac, extEn_q};
	wire [31:0] rdMux = (aAddr == `SXM_ADDR_CTRL) ? {30'h0000_0000, ctrl_q} :
		(aAddr == `SXM_ADDR_STATUS) ? statusWord :
		(aAddr == `SXM_ADDR_COUNT) ? {cntB_q, cntA_q} : 32'h0000_0000;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			wrPend_q <= 1'b0;
			wrAddr_q <= '0;
			rdata_q <= '0;
		end else begin
			wrPend_q <= take && hwrite;
			wrAddr_q <= aAddr;
			if (take && !hwrite)
				rdata_q <= rdMux;
		end
	end
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_q <= `SXM_CTRL_RESET;
			cntA_q <= '0;
			cntB_q <= '0;
		end else begin
			if (wrPend_q && wrAddr_q == `SXM_ADDR_CTRL)
				ctrl_q <= hwdata[1:0]; // R4
			if (aIngVal_q)
				cntA_q <= incr16(cntA_q);
			if (bIngVal_q)
				cntB_q <= incr16(cntB_q);
		end
	end
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_q;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	a_pause_follow: assert property (latched_q |-> (portAPauseEnable == (pause_q && active))) // R1
		else $error("pause enable mismatch");
	a_role_drive: assert property (isMac |-> (portATxNibbleOe && !portATxClockOe)) // R2
		else $error("MAC role pin directions wrong");
	a_portb_fixed: assert property (active |-> (portBOe && egrBReady == fallEv)) // R3
		else $error("port B not in PHY role");
	a_col_gate_a: assert property ($rose(portACollisionOut) |-> $past(halfA && portAColEvent && isPhy)) // R7
		else $error("port A collision without cause");
	a_rx_fall_launch: assert property (isPhy && $changed(portARxNibbleOut) |-> $past(fallEv)) // R8
		else $error("port A rx data changed off falling edge");
	a_no_rx_clock: assert property (!portARxClockOe) // R9
		else $error("port A rx clock driven");
	a_ing_enable: assert property (isPhy && ingAValid |-> $past(sync2_q[`SXM_S_ATXEN] && riseEv)) // R6
		else $error("ingress without sampled enable");
	a_col_gate_b: assert property (portBCollision |-> $past(halfB && portBColEvent)) // R17
		else $error("port B collision without cause");
	a_ext_off: assert property (latched_q && !extEn_q |-> ##1 !portBOe && !portATxClockOe && !portARxValidOe) // R19
		else $error("interface active while disabled");
	a_strap_hold: assert property (latched_q |=> $stable(mode_q) && $stable(pause_q)) // R21
		else $error("strap state changed after capture");
	// cycles since the link clock last toggled, counted apart from the divider
	logic [7:0] clkRun_q;
	logic clkSeen_q;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			clkRun_q <= '0;
			clkSeen_q <= 1'b0;
		end else begin
			clkSeen_q <= linkClk_q;
			clkRun_q <= (clkSeen_q != linkClk_q) ? 8'h01 : clkRun_q + 8'h01;
		end
	end
	a_clk_half: assert property ((clkSeen_q != linkClk_q) |-> (clkRun_q == 8'(`SXM_HALF_CYCLES))) // R5
		else $error("link clock half period wrong");
	c_phy_ingress: cover property (isPhy && ingAValid);
	c_mac_ingress: cover property (isMac && ingAValid);
	c_port_b_col: cover property (portBCollision);
	c_mac_egress: cover property (isMac && egrAReady && egrAValid);
endmodule : sxm_ext_mii

/* File: hw/sxm_cfg.svh */
`ifndef SXM_CFG_SVH
`define SXM_CFG_SVH
// ****************************************
// register map
// ****************************************
`define SXM_ADDR_CTRL 8'h00
`define SXM_ADDR_STATUS 8'h04
`define SXM_ADDR_COUNT 8'h08
`define SXM_ADDR_MSB 7
`define SXM_CTRL_HALF_A 0
`define SXM_CTRL_HALF_B 1
`define SXM_CTRL_RESET 2'h0
// ****************************************
// timing
// ****************************************
`define SXM_SYS_PERIOD_NS 8
`define SXM_LINK_PERIOD_NS 160
`define SXM_HALF_CYCLES ((`SXM_LINK_PERIOD_NS / 2) / `SXM_SYS_PERIOD_NS)
`define SXM_STRAP_WAIT 2'h3
// ****************************************
// synchroniser bit positions
// ****************************************
`define SXM_SYNC_W 22
`define SXM_S_EXT 0
`define SXM_S_ROLE 1
`define SXM_S_PAUSE 2
`define SXM_S_IFTYPE 3
`define SXM_S_ATXCLK 4
`define SXM_S_ATXNIB 5
`define SXM_S_ATXEN 9
`define SXM_S_ACOL 10
`define SXM_S_ARXDV 11
`define SXM_S_ARXNIB 12
`define SXM_S_ARXCLK 16
`define SXM_S_BTXNIB 17
`define SXM_S_BTXEN 21
`endif

/* File: hw/sxm_pkg.sv */
package sxm_pkg;
	typedef enum logic [2:0] {
		SXM_OFF = 3'b001,
		SXM_PHY = 3'b010,
		SXM_MAC = 3'b100
	} sxm_mode_t;
	typedef logic [3:0] sxm_nibble_t;
endpackage : sxm_pkg

/* File: verification/sxm_far_end.sv */
`timescale 1ns/10ps
// ********************
// far side of the external ports
// ********************
module sxm_far_end import sxm_pkg::*; (
	input wire logic aTxClk, // device port A tx clock
	input wire logic bTxClk, // device port B tx clock
	output logic aTxClkIn, // port A tx clock we supply
	output logic aRxClkIn, // port A rx clock we supply
	output sxm_nibble_t aTxNib, // port A tx data
	output logic aTxEn, // port A tx enable
	output sxm_nibble_t bTxNib, // port B tx data
	output logic bTxEn, // port B tx enable
	output sxm_nibble_t aRxNib, // port A rx data
	output logic aRxDv, // port A rx valid
	output logic aCol // port A collision
);
	initial begin
		{aTxClkIn, aRxClkIn, aTxNib, aTxEn, bTxNib, bTxEn, aRxNib, aRxDv, aCol} = '0;
	end
	// mac side: change after the fall so the nibble is steady at the rise
	task automatic phySend(input logic portB, input sxm_nibble_t n, input logic en);
		if (portB) begin
			@(negedge bTxClk);
			bTxNib <= n;
			bTxEn <= en;
		end else begin
			@(negedge aTxClk);
			aTxNib <= n;
			aTxEn <= en;
		end
	endtask : phySend
	// phy side: one link period, both clocks stand still between calls
	task automatic macSend(input sxm_nibble_t n, input logic dv);
		aRxNib = n;
		aRxDv = dv;
		#80;
		aTxClkIn = 1'h1;
		aRxClkIn = 1'h1;
		#80;
		aTxClkIn = 1'h0;
		aRxClkIn = 1'h0;
	endtask : macSend
	// rx lines have no pull, so a released bus shows a changed pattern
	task automatic macIdle(input logic c);
		#2;
		aRxDv = 1'h0;
		aRxNib = ~aRxNib;
		aCol = c;
	endtask : macIdle
endmodule : sxm_far_end

/* File: verification/testbench.sv */
`timescale 1ns/10ps
// ********************
// testbench
// ********************
module testbench import sxm_pkg::*; ;
	logic sys_clk, reset_n, hsel, hwrite, hready, hreadyout, hresp, rdPhase, en;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic extPortEnableStrap, portARoleSelect, portAPauseEnableStrap, interfaceTypeStrap;
	logic portATxClockIn, portATxClockOut, portATxClockOe, portATxNibbleOe, portATxEnableIn, portATxEnableOut;
	logic portATxEnableOe, portACollisionIn, portACollisionOut, portACollisionOe, portARxValidIn, portARxValidOut;
	logic portARxValidOe, portARxNibbleOe, portARxClockIn, portARxClockOut, portARxClockOe, portBTxClock;
	logic portBTxEnable, portBCollision, portBRxValid, portBRxClock, portBOe, portAColEvent, portBColEvent;
	logic egrAValid, egrAReady, egrBValid, egrBReady, ingAValid, ingBValid, portAColSeen, portAPauseEnable;
	sxm_nibble_t portATxNibbleIn, portATxNibbleOut, portARxNibbleIn, portARxNibbleOut, portBTxNibble;
	sxm_nibble_t portBRxNibble, egrANibble, egrBNibble, ingANibble, ingBNibble, nib;
	sxm_nibble_t expA[$], expB[$], expRx[$], expRxB[$];
	logic [31:0] expRd[$];
	int miscompares, nCompared, seed, nA;
	sxm_ext_mii i_sxm_ext_mii (.sys_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
		.hreadyout, .hrdata, .hresp, .extPortEnableStrap, .portARoleSelect, .portAPauseEnableStrap,
		.interfaceTypeStrap, .portATxClockIn, .portATxClockOut, .portATxClockOe, .portATxNibbleIn,
		.portATxNibbleOut, .portATxNibbleOe, .portATxEnableIn, .portATxEnableOut, .portATxEnableOe,
		.portACollisionIn, .portACollisionOut, .portACollisionOe, .portARxValidIn, .portARxValidOut,
		.portARxValidOe, .portARxNibbleIn, .portARxNibbleOut, .portARxNibbleOe, .portARxClockIn,
		.portARxClockOut, .portARxClockOe, .portBTxClock, .portBTxNibble, .portBTxEnable, .portBCollision,
		.portBRxValid, .portBRxNibble, .portBRxClock, .portBOe, .portAColEvent, .portBColEvent, .egrANibble,
		.egrAValid, .egrAReady, .egrBNibble, .egrBValid, .egrBReady, .ingANibble, .ingAValid, .ingBNibble,
		.ingBValid, .portAColSeen, .portAPauseEnable);
	sxm_far_end i_sxm_far_end (.aTxClk(portATxClockOut), .bTxClk(portBTxClock), .aTxClkIn(portATxClockIn),
		.aRxClkIn(portARxClockIn), .aTxNib(portATxNibbleIn), .aTxEn(portATxEnableIn), .bTxNib(portBTxNibble),
		.bTxEn(portBTxEnable), .aRxNib(portARxNibbleIn), .aRxDv(portARxValidIn), .aCol(portACollisionIn));
	assign hready = hreadyout;
	initial begin
		sys_clk = 1'h0;
		forever #4 sys_clk = ~sys_clk;
	end
	task checkWord(input logic [31:0] got, input logic [31:0] exp);
		nCompared++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %0t: got %h want %h", $time, got, exp);
		end
	endtask : checkWord
	task checkNib(input sxm_nibble_t got, input sxm_nibble_t exp);
		nCompared++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %0t: nibble %h want %h", $time, got, exp);
		end
	endtask : checkNib
	task stop_test;
		if (miscompares == 0 && nCompared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : stop_test
	task waitReady;
		for (int n = 0; n < 50; n++) begin
			@(posedge sys_clk);
			if (hreadyout === 1'h1) return;
		end
		miscompares++;
		stop_test();
	endtask : waitReady
	task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		waitReady();
		htrans <= 2'h0;
		hsel <= 1'h0;
		hwdata <= d;
		rdPhase <= ~wr;
		if (!wr) expRd.push_back(d);
		waitReady();
		rdPhase <= 1'h0;
	endtask : ahb
	// straps in order: external enable, role, pause, interface type
	task doReset(input logic [3:0] s);
		@(posedge sys_clk);
		reset_n <= 1'h0;
		{extPortEnableStrap, portARoleSelect, portAPauseEnableStrap, interfaceTypeStrap} <= s;
		repeat (10) @(posedge sys_clk);
		reset_n <= 1'h1;
		repeat (8) @(posedge sys_clk);
		#1;
	endtask : doReset
	always @(posedge sys_clk) begin
		if (rdPhase === 1'h1 && hreadyout === 1'h1) begin
			checkWord(hrdata, expRd.pop_front());
			checkWord({31'h0, hresp}, 32'h0);
		end
		if (ingAValid === 1'h1) checkNib(ingANibble, expA.size() ? expA.pop_front() : 4'hx);
		if (ingBValid === 1'h1) checkNib(ingBNibble, expB.size() ? expB.pop_front() : 4'hx);
		if (egrAValid === 1'h1 && egrAReady === 1'h1) begin
			expRx.push_back(egrANibble);
			egrANibble <= 4'($random(seed));
		end
		if (egrBValid === 1'h1 && egrBReady === 1'h1) begin
			expRxB.push_back(egrBNibble);
			egrBNibble <= 4'($random(seed));
		end
	end
	always @(posedge portATxClockOut)
		if (portARxValidOe === 1'h1 && portARxValidOut === 1'h1)
			checkNib(portARxNibbleOut, expRx.size() ? expRx.pop_front() : 4'hx);
	always @(negedge portATxClockIn)
		if (portATxEnableOe === 1'h1 && portATxEnableOut === 1'h1)
			checkNib(portATxNibbleOut, expRx.size() ? expRx.pop_front() : 4'hx);
	always @(posedge portBRxClock)
		if (portBRxValid === 1'h1) checkNib(portBRxNibble, expRxB.size() ? expRxB.pop_front() : 4'hx);
	initial begin
		seed = 35363;
		{hsel, hwrite, rdPhase, portAColEvent, portBColEvent, egrAValid, egrBValid, reset_n} = '0;
		{haddr, hwdata, htrans, egrANibble, egrBNibble} = '0;
		{extPortEnableStrap, portARoleSelect, portAPauseEnableStrap, interfaceTypeStrap} = '0;
		hsize = 3'h2;
		miscompares = 0;
		nCompared = 0;
		nA = 0;
		doReset(4'ha);
		checkWord({portATxClockOe, portATxNibbleOe, portARxValidOe, portACollisionOe, portARxClockOe, portBOe,
			portAPauseEnable}, 7'h5b);
		ahb(1'h0, 32'h0000_0004, 32'h0000_0015);
		@(posedge sys_clk);
		{extPortEnableStrap, portARoleSelect, portAPauseEnableStrap} <= 3'h2;
		ahb(1'h1, 32'h0000_0004, 32'h0000_ffff);
		repeat (6) @(posedge sys_clk);
		ahb(1'h0, 32'h0000_0004, 32'h0000_0015);
		ahb(1'h0, 32'h0000_000c, 32'h0000_0000);
		for (int h = 0; h < 2; h++) begin
			ahb(1'h1, 32'h0000_0000, {30'h0, h[0], h[0]});
			ahb(1'h0, 32'h0000_0000, {30'h0, h[0], h[0]});
			@(posedge sys_clk);
			{portAColEvent, portBColEvent} <= 2'h3;
			repeat (3) @(posedge sys_clk);
			#1;
			checkWord({portACollisionOut, portBCollision}, {h[0], h[0]});
			@(posedge sys_clk);
			{portAColEvent, portBColEvent} <= 2'h0;
		end
		repeat (2) @(posedge sys_clk);
		#1;
		checkWord({portACollisionOut, portBCollision}, 2'h0);
		for (int i = 0; i < 12; i++) begin
			nib = 4'($random(seed));
			en = (i % 4) != 0;
			if (en) begin
				expA.push_back(nib);
				expB.push_back(~nib);
				nA++;
			end
			fork
				i_sxm_far_end.phySend(1'h0, nib, en);
				i_sxm_far_end.phySend(1'h1, ~nib, en);
			join
		end
		fork
			i_sxm_far_end.phySend(1'h0, 4'h0, 1'h0);
			i_sxm_far_end.phySend(1'h1, 4'h0, 1'h0);
		join
		repeat (30) @(posedge sys_clk);
		checkWord(expA.size() + expB.size(), 32'h0);
		ahb(1'h0, 32'h0000_0008, {nA[15:0], nA[15:0]});
		@(posedge sys_clk);
		{egrAValid, egrBValid} <= 2'h3;
		repeat (100) @(posedge sys_clk);
		{egrAValid, egrBValid} <= 2'h0;
		repeat (40) @(posedge sys_clk);
		checkWord(expRx.size() + expRxB.size(), 32'h0);
		doReset(4'hc);
		checkWord({portATxNibbleOe, portATxEnableOe, portATxClockOe, portACollisionOe, portBOe,
			portAPauseEnable}, 6'h32);
		ahb(1'h0, 32'h0000_0004, 32'h0000_0033);
		@(posedge sys_clk);
		egrAValid <= 1'h1;
		// keep the supplied link clocks off the sampling edge
		#2;
		for (int i = 0; i < 8; i++) begin
			nib = 4'($random(seed));
			if (i != 3) expA.push_back(nib);
			i_sxm_far_end.macSend(nib, i != 3);
		end
		@(posedge sys_clk);
		egrAValid <= 1'h0;
		i_sxm_far_end.macIdle(1'h1);
		repeat (8) @(posedge sys_clk);
		#1;
		checkWord(portAColSeen, 1'h1);
		checkWord(expA.size() + expRx.size(), 32'h0);
		for (int k = 0; k < 2; k++) begin
			doReset(k[0] ? 4'hb : 4'h2);
			checkWord({portBOe, portATxClockOe, portARxValidOe}, 3'h0);
		end
		stop_test();
	end
	initial begin
		#400000;
		miscompares++;
		stop_test();
	end
endmodule : testbench
